// >>> hdl/surface_descriptor_decoder.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module surface_descriptor_decoder
#(
	parameter bit FLOAT_ONLY = 1'b0
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire logic [7:0] req_index,
	input wire logic [1:0] req_kind,
	input wire logic req_four_by_two,
	input wire logic req_float_ret,
	input wire logic req_array,
	output logic dec_valid,
	output logic [2:0] dec_kind,
	output logic dec_null,
	output logic dec_reserved_kind,
	output logic dec_ret_fixed,
	output logic [8:0] dec_format,
	output logic dec_format_used,
	output logic dec_line_skip,
	output logic dec_line_ofs,
	output logic dec_mip_side,
	output logic dec_corner_mean,
	output logic [5:0] dec_faces,
	output logic [31:0] dec_desc_addr,
	output logic dec_mem_go,
	output logic dec_mem_write,
	output logic dec_zero_data,
	output logic dec_ptr_bad
);
	typedef enum {st_idle, st_entry, st_desc, st_present} state_t;
	state_t state_q;

	logic [31:0] desc_base_q;
	logic [7:0] table_addr_q;
	logic [7:0] desc_wr_addr_q;
	logic [7:0] idx_q;
	logic [1:0] kind_q;
	logic four_by_two_q;
	logic float_ret_q;
	logic array_q;
	logic [31:0] entry_q;
	logic [31:0] table_rd;
	logic [31:0] desc_rd;
	logic [7:0] desc_slot;
	logic [31:0] desc_addr;
	logic table_we;
	logic desc_we;
	logic [3:0] drop_count_q;
	logic [1:0] dec_msg_q;
	logic desc_ready_q;

	assign table_we = reg_wr && (reg_addr == surf_desc_pkg::REG_TABLE_WR);
	assign desc_we = reg_wr && (reg_addr == surf_desc_pkg::REG_DESC_WR_DATA);
	// Pointer is 32-byte aligned, so the low five bits are forced clear
	assign desc_addr = desc_base_q + {entry_q[surf_desc_pkg::PTR_MSB:surf_desc_pkg::PTR_LSB], 5'h00};
	// Descriptors are held by slot: bits 12:5 of base plus pointer, one slot per 32-byte step
	assign desc_slot = desc_addr[12:5];

	word_store #(.DEPTH(surf_desc_pkg::TABLE_ENTRIES), .AW(surf_desc_pkg::INDEX_W)) u_table
	(
		.clk(clk),
		.wr_en(table_we),
		.wr_addr(table_addr_q),
		.wr_data(reg_wdata),
		.rd_addr(idx_q),
		.rd_data(table_rd)
	);

	word_store #(.DEPTH(surf_desc_pkg::DESC_SLOTS), .AW(8)) u_desc
	(
		.clk(clk),
		.wr_en(desc_we),
		.wr_addr(desc_wr_addr_q),
		.wr_data(reg_wdata),
		.rd_addr(desc_slot),
		.rd_data(desc_rd)
	);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			desc_base_q <= surf_desc_pkg::RESET_WORD;
			table_addr_q <= 8'h00;
			desc_wr_addr_q <= 8'h00;
		end
		else if (reg_wr)
		begin
			if (reg_addr == surf_desc_pkg::REG_DESC_BASE)
			begin
				desc_base_q <= reg_wdata;
			end
			else if (reg_addr == surf_desc_pkg::REG_TABLE_ADDR)
			begin
				table_addr_q <= reg_wdata[7:0];
			end
			else if (reg_addr == surf_desc_pkg::REG_DESC_WR_ADDR)
			begin
				desc_wr_addr_q <= reg_wdata[7:0];
			end
			else if (reg_addr == surf_desc_pkg::REG_TABLE_WR)
			begin
				// Auto-increment lets software stream the whole table
				table_addr_q <= table_addr_q + 8'h01;
			end
			else if (reg_addr == surf_desc_pkg::REG_DESC_WR_DATA)
			begin
				desc_wr_addr_q <= desc_wr_addr_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			reg_rdata <= 32'h00000000;
		end
		else if (reg_rd)
		begin
			if (reg_addr == surf_desc_pkg::REG_DESC_BASE)
			begin
				reg_rdata <= desc_base_q;
			end
			else if (reg_addr == surf_desc_pkg::REG_TABLE_ADDR)
			begin
				reg_rdata <= {24'h000000, table_addr_q};
			end
			else if (reg_addr == surf_desc_pkg::REG_DESC_WR_ADDR)
			begin
				reg_rdata <= {24'h000000, desc_wr_addr_q};
			end
			else if (reg_addr == surf_desc_pkg::REG_STATUS)
			begin
				reg_rdata <= {24'h000000, drop_count_q, dec_ptr_bad, dec_null, state_q == st_idle, dec_valid};
			end
			else if (reg_addr == surf_desc_pkg::REG_LAST_FIELDS)
			begin
				reg_rdata <= {dec_kind, 4'h0, dec_format, 4'h0, dec_line_skip, dec_line_ofs, dec_mip_side,
					dec_corner_mean, 2'h0, dec_faces};
			end
			else
			begin
				reg_rdata <= 32'h00000000;
			end
		end
		else
		begin
			reg_rdata <= 32'h00000000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_q <= st_idle;
			idx_q <= 8'h00;
			kind_q <= 2'h0;
			four_by_two_q <= 1'b0;
			float_ret_q <= 1'b0;
			array_q <= 1'b0;
			entry_q <= surf_desc_pkg::RESET_WORD;
		end
		else
		begin
			case (state_q)
				st_idle:
				begin
					if (req_valid)
					begin
						idx_q <= req_index;
						kind_q <= req_kind;
						four_by_two_q <= req_four_by_two;
						float_ret_q <= req_float_ret;
						array_q <= req_array;
						state_q <= st_entry;
					end
				end
				st_entry:
				begin
					state_q <= st_desc;
				end
				st_desc:
				begin
					entry_q <= table_rd;
					state_q <= st_present;
				end
				st_present:
				begin
					if (desc_ready_q)
						state_q <= st_idle;
				end
				default:
				begin
					state_q <= st_idle;
				end
			endcase
		end
	end

	// Table read lands in st_desc, descriptor read one cycle after entry_q settles
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			desc_ready_q <= 1'b0;
		end
		else
		begin
			desc_ready_q <= (state_q == st_present) && !desc_ready_q;
		end
	end

	logic [2:0] k;
	logic is_null;
	logic plain_2d;
	assign k = desc_rd[surf_desc_pkg::KIND_MSB:surf_desc_pkg::KIND_LSB];
	assign is_null = (k == surf_desc_pkg::kind_null);
	assign plain_2d = (k == surf_desc_pkg::kind_two_dim) && !array_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dec_valid <= 1'b0;
			dec_kind <= 3'h0;
			dec_null <= 1'b0;
			dec_reserved_kind <= 1'b0;
			dec_ret_fixed <= 1'b0;
			dec_format <= 9'h000;
			dec_format_used <= 1'b0;
			dec_line_skip <= 1'b0;
			dec_line_ofs <= 1'b0;
			dec_mip_side <= 1'b0;
			dec_corner_mean <= 1'b0;
			dec_faces <= 6'h00;
			dec_desc_addr <= 32'h00000000;
			dec_ptr_bad <= 1'b0;
			dec_msg_q <= 2'h0;
		end
		else
		begin
			dec_valid <= desc_ready_q;
			if (desc_ready_q)
			begin
				dec_kind <= k;
				dec_null <= is_null;
				dec_reserved_kind <= (k == 3'h5) || (k == 3'h6);
				dec_desc_addr <= desc_addr;
				dec_ptr_bad <= (entry_q[4:0] != 5'h00);
				// Format survives null since it must still be programmed consistently
				dec_format <= desc_rd[surf_desc_pkg::FMT_MSB:surf_desc_pkg::FMT_LSB];
				dec_format_used <= (kind_q == surf_desc_pkg::msg_fmt_write);
				dec_msg_q <= kind_q;
				// Fixed return only when asked for float, not four-by-two, and variant allows it
				dec_ret_fixed <= !is_null && !FLOAT_ONLY && float_ret_q && !four_by_two_q
					&& desc_rd[surf_desc_pkg::RET_FMT_BIT];
				dec_line_skip <= !is_null && plain_2d && desc_rd[surf_desc_pkg::LINE_SKIP_BIT];
				dec_line_ofs <= !is_null && plain_2d && desc_rd[surf_desc_pkg::LINE_SKIP_BIT]
					&& desc_rd[surf_desc_pkg::LINE_OFS_BIT];
				dec_mip_side <= !is_null && plain_2d && desc_rd[surf_desc_pkg::MIP_SIDE_BIT];
				dec_corner_mean <= !is_null && (k == surf_desc_pkg::kind_cube)
					&& desc_rd[surf_desc_pkg::CORNER_BIT];
				dec_faces <= (!is_null && (k == surf_desc_pkg::kind_cube))
					? desc_rd[surf_desc_pkg::FACE_MSB:surf_desc_pkg::FACE_LSB] : 6'h00;
			end
		end
	end

	// Memory request issues one cycle after the decode is presented
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dec_mem_go <= 1'b0;
			dec_mem_write <= 1'b0;
			dec_zero_data <= 1'b0;
		end
		else
		begin
			dec_mem_go <= dec_valid && !dec_null;
			dec_mem_write <= dec_valid && !dec_null
				&& (dec_msg_q == surf_desc_pkg::msg_write || dec_msg_q == surf_desc_pkg::msg_fmt_write);
			dec_zero_data <= dec_valid && dec_null
				&& (dec_msg_q == surf_desc_pkg::msg_read || dec_msg_q == surf_desc_pkg::msg_sample);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			drop_count_q <= 4'h0;
		end
		else if (dec_valid && dec_null
			&& (dec_msg_q == surf_desc_pkg::msg_write || dec_msg_q == surf_desc_pkg::msg_fmt_write))
		begin
			drop_count_q <= drop_count_q + 4'h1;
		end
	end

	sequence seq_decode;
		dec_valid ##1 !dec_valid;
	endsequence

	property prop_null_no_mem;
		@(posedge clk) disable iff (!rst_n)
		(dec_valid && dec_null) |=> !dec_mem_go && !dec_mem_write;
	endproperty
	AST_NULL_WRITE_DROPPED: assert property (prop_null_no_mem)
		else $error("memory access issued for null surface");
	AST_NULL_READ_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		(dec_valid && dec_null && dec_msg_q == surf_desc_pkg::msg_read) |=> dec_zero_data)
		else $error("null read did not return zeros");
	AST_DECODE_BEFORE_ACCESS: assert property (@(posedge clk) disable iff (!rst_n)
		dec_mem_go |-> $past(dec_valid))
		else $error("memory access without prior decode");
	AST_FOUR_BY_TWO_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == st_present && four_by_two_q) ##1 1'b1 |=> !dec_ret_fixed)
		else $error("four-by-two message got fixed return");
	AST_LINE_OFS_NEEDS_SKIP: assert property (@(posedge clk) disable iff (!rst_n)
		dec_line_ofs |-> dec_line_skip)
		else $error("start line offset without line skip");
	AST_SIDE_ONLY_2D: assert property (@(posedge clk) disable iff (!rst_n)
		dec_mip_side |-> dec_kind == surf_desc_pkg::kind_two_dim)
		else $error("side mip layout on non 2D surface");
	AST_FACES_CUBE_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
		(dec_faces != 6'h00 || dec_corner_mean) |-> dec_kind == surf_desc_pkg::kind_cube)
		else $error("face mask on non cube surface");
	AST_NULL_FIELDS_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		(dec_null && dec_valid) |-> !dec_line_skip && !dec_mip_side && !dec_ret_fixed)
		else $error("null surface kept optional fields");
	AST_REQ_TO_DECODE: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == st_idle && req_valid) |-> ##5 seq_decode)
		else $error("decode not presented five cycles after request");
endmodule

// >>> hdl/surf_desc_pkg.sv
package surf_desc_pkg;
	localparam int TABLE_ENTRIES = 256;
	localparam int INDEX_W = 8;
	localparam int PTR_LSB = 5;
	localparam int PTR_MSB = 31;
	localparam int KIND_MSB = 31;
	localparam int KIND_LSB = 29;
	localparam int RET_FMT_BIT = 27;
	localparam int FMT_MSB = 26;
	localparam int FMT_LSB = 18;
	localparam int LINE_SKIP_BIT = 12;
	localparam int LINE_OFS_BIT = 11;
	localparam int MIP_SIDE_BIT = 10;
	localparam int CORNER_BIT = 9;
	localparam int FACE_MSB = 5;
	localparam int FACE_LSB = 0;
	localparam logic [7:0] REG_TABLE_WR = 8'h00;
	localparam logic [7:0] REG_DESC_BASE = 8'h04;
	localparam logic [7:0] REG_DESC_WR_ADDR = 8'h08;
	localparam logic [7:0] REG_DESC_WR_DATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_LAST_FIELDS = 8'h14;
	localparam logic [7:0] REG_TABLE_ADDR = 8'h18;
	localparam int DESC_SLOTS = 256;
	localparam logic [31:0] RESET_WORD = 32'h00000000;
	typedef enum logic [2:0] {
		kind_one_dim = 3'h0,
		kind_two_dim = 3'h1,
		kind_volumetric = 3'h2,
		kind_cube = 3'h3,
		kind_buffer_element = 3'h4,
		kind_null = 3'h7
	} surf_kind_t;
	typedef enum logic [1:0] {
		msg_read = 2'h0,
		msg_write = 2'h1,
		msg_sample = 2'h2,
		msg_fmt_write = 2'h3
	} msg_kind_t;
endpackage

// >>> hdl/word_store.sv
`timescale 1ns/1ps
module word_store
#(
	parameter int DEPTH = 256,
	parameter int AW = 8
)
(
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [31:0] rd_data
);
	logic [31:0] mem [DEPTH];

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk)
	begin
		rd_data <= mem[rd_addr];
	end
endmodule

// >>> verification/msg_source.sv
`timescale 1ns/1ps
module msg_source
(
	input wire logic clk,
	output logic req_valid,
	output logic [7:0] req_index,
	output logic [1:0] req_kind,
	output logic req_four_by_two,
	output logic req_float_ret,
	output logic req_array
);
	initial
	begin
		req_valid = 1'b0;
		req_index = 8'h00;
		req_kind = 2'h0;
		req_four_by_two = 1'b0;
		req_float_ret = 1'b0;
		req_array = 1'b0;
	end
	task automatic send(input logic [7:0] i, input logic [1:0] k, input logic f, input logic t, input logic a);
	begin
		@(posedge clk);
		req_valid <= 1'b1;
		req_index <= i;
		req_kind <= k;
		req_four_by_two <= f;
		req_float_ret <= t;
		req_array <= a;
		@(posedge clk);
		req_valid <= 1'b0;
		// Inverted after release so a stale qualifier never looks live
		req_index <= ~i;
		req_kind <= ~k;
		req_four_by_two <= ~f;
		req_float_ret <= ~t;
		req_array <= ~a;
	end
	endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] dec_desc_addr;
	logic req_valid, req_four_by_two, req_float_ret, req_array;
	logic [7:0] req_index;
	logic [1:0] req_kind;
	logic dec_valid, dec_null, dec_reserved_kind, dec_ret_fixed, dec_format_used, dec_line_skip;
	logic dec_line_ofs, dec_mip_side, dec_corner_mean, dec_mem_go, dec_mem_write, dec_zero_data, dec_ptr_bad;
	logic [2:0] dec_kind;
	logic [8:0] dec_format;
	logic [5:0] dec_faces;
	int num_errors = 0;
	int n_checks = 0;
	always #4 clk = ~clk;
	msg_source src_u (.clk, .req_valid, .req_index, .req_kind, .req_four_by_two, .req_float_ret, .req_array);
	surface_descriptor_decoder #(.FLOAT_ONLY(1'b0)) dut_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .req_valid, .req_index, .req_kind, .req_four_by_two, .req_float_ret, .req_array,
		.dec_valid, .dec_kind, .dec_null, .dec_reserved_kind, .dec_ret_fixed, .dec_format, .dec_format_used,
		.dec_line_skip, .dec_line_ofs, .dec_mip_side, .dec_corner_mean, .dec_faces, .dec_desc_addr,
		.dec_mem_go, .dec_mem_write, .dec_zero_data, .dec_ptr_bad);
	task automatic conclude;
	begin
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
	begin
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, e);
	end
	endtask
	// Base 0x2000 wraps out of the 8-bit slot, so the slot equals the table offset
	task automatic setup(input logic [7:0] i, input logic [31:0] ent, input logic [31:0] dw0);
	begin
		wr(surf_desc_pkg::REG_TABLE_ADDR, {24'h0, i});
		wr(surf_desc_pkg::REG_TABLE_WR, ent);
		wr(surf_desc_pkg::REG_DESC_WR_ADDR, {24'h0, 8'((32'h00002000 + {ent[31:5], 5'h00}) >> 5)});
		wr(surf_desc_pkg::REG_DESC_WR_DATA, dw0);
	end
	endtask
	task automatic look(input logic [7:0] i, input logic [1:0] k, input logic f, input logic t, input logic a,
		input logic [2:0] e);
		int n;
	begin
		src_u.send(i, k, f, t, a);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (dec_valid !== 1'b1 && n < 20);
		chk(32'(n), 32'h00000005);
		if (n >= 20)
			conclude();
		@(negedge clk);
		chk({dec_mem_go, dec_mem_write, dec_zero_data}, e);
	end
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		wr(surf_desc_pkg::REG_DESC_BASE, 32'h00002000);
		rd(surf_desc_pkg::REG_DESC_BASE, 32'h00002000);
		rd(8'hFC, 32'h00000000);
		$display("test regs done");
		for (int k = 0; k < 8; k++)
		begin
			setup(8'(k), 32'(k) << 5, {3'(k), 2'h0, 9'h1A5, 18'h0});
			for (int m = 0; m < 4; m++)
			begin
				look(8'(k), 2'(m), 1'b0, 1'b0, 1'b0, {k != 7, k != 7 && m % 2 == 1, k == 7 && m % 2 == 0});
				chk({dec_kind, dec_null, dec_reserved_kind, dec_format}, {3'(k), k == 7, k == 5 || k == 6, 9'h1A5});
				chk(dec_desc_addr, 32'h00002000 + (32'(k) << 5));
				if (k != 7)
					chk(dec_format_used, m == 3);
			end
		end
		rd(surf_desc_pkg::REG_STATUS, 32'h00000026);
		$display("test kinds done");
		setup(8'h10, 32'h00000200, {3'h1, 2'h1, 27'h0});
		for (int j = 0; j < 3; j++)
		begin
			look(8'h10, 2'h2, j == 1, j != 2, 1'b0, 3'b100);
			chk(dec_ret_fixed, j == 0);
		end
		$display("test return done");
		setup(8'h20, 32'h00000400, {3'h1, 16'h0, 3'h7, 10'h0});
		for (int a = 0; a < 2; a++)
		begin
			look(8'h20, 2'h0, 1'b0, 1'b1, a[0], 3'b100);
			chk({dec_line_skip, dec_line_ofs, dec_mip_side}, a == 0 ? 3'h7 : 3'h0);
		end
		setup(8'h21, 32'h00000420, {3'h1, 17'h0, 1'b1, 11'h0});
		look(8'h21, 2'h0, 1'b0, 1'b1, 1'b0, 3'b100);
		chk({dec_line_skip, dec_line_ofs}, 2'h0);
		$display("test lines done");
		setup(8'h30, 32'h00000600, {3'h3, 19'h0, 1'b1, 3'h0, 6'h3F});
		look(8'h30, 2'h2, 1'b0, 1'b1, 1'b0, 3'b100);
		chk({dec_corner_mean, dec_faces}, 7'h7F);
		rd(surf_desc_pkg::REG_LAST_FIELDS, 32'h6000013F);
		setup(8'h31, 32'h00000620, {3'h1, 19'h0, 1'b0, 3'h0, 6'h21});
		look(8'h31, 2'h2, 1'b0, 1'b1, 1'b0, 3'b100);
		chk(dec_faces, 6'h00);
		$display("test cube done");
		setup(8'hFF, 32'h00001FE1, 32'h00000000);
		look(8'hFF, 2'h0, 1'b0, 1'b0, 1'b0, 3'b100);
		chk(32'(dec_ptr_bad), 32'h00000001);
		chk(dec_desc_addr, 32'h00003FE0);
		$display("test pointer done");
		conclude();
	end
endmodule
